// ==== core/scc_pkg.sv ====
/*
  Constants for the serial codec control register bank: port numbers,
  field positions of both control halves, reset values and frame timing.
  Assumes a single 20 MHz clock and a processor that writes the halves
  through two I/O ports.
*/
`default_nettype none
package scc_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 50;
  // I/O port numbers of the two halves
  localparam logic PORT_LOWER = 1'h0;
  localparam logic PORT_UPPER = 1'h1;
  // lower half field positions
  localparam int FLAG_LSB = 0;
  localparam int FLAG_W = 4;
  localparam int MASK_LSB = 4;
  localparam int UPPER_ACCESS_BIT = 8;
  localparam int EXT_FRAMING_BIT = 9;
  localparam int EXT_FLAG_BIT = 10;
  localparam int COMPAND_MODE_BIT = 11;
  localparam int COMPAND_EN_LSB = 12;
  localparam int COMPAND_EN_W = 2;
  localparam int LAW_SELECT_BIT = 14;
  localparam int SHIFT_CLK_DIR_BIT = 15;
  // upper half field positions
  localparam int MODULUS_LSB = 0;
  localparam int MODULUS_W = 8;
  localparam int PRESCALE_LSB = 8;
  localparam int PRESCALE_W = 4;
  localparam int FR_WIDTH_BIT = 12;
  localparam int IO_CTRL_LSB = 13;
  localparam int IO_CTRL_W = 2;
  localparam int RESERVED_BIT = 15;
  // flag index fed by the active frame pulse
  localparam int FRAME_FLAG_IDX = 0;
  // reset values: serial clock held as an input until software changes it
  localparam logic [15:0] LOWER_RESET = 16'h8000;
  localparam logic [15:0] UPPER_RESET = 16'h0000;
  // frame period is modulus plus this many serial clocks
  localparam logic [8:0] FRAME_EXTRA = 9'h002;
  // frame pulse widths in serial clocks
  localparam logic [8:0] LONG_FR_CLKS = 9'h008;
  localparam logic [8:0] SHORT_FR_CLKS = 9'h001;
endpackage
`default_nettype wire

// ==== core/scc_frame_gen.sv ====
/*
  Serial clock prescaler and frame pulse generator.
  Assumes sclk_i is synchronous to clk; in input mode its rising edges
  advance the frame counter instead of the prescaler.
*/
`default_nettype none
module scc_frame_gen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // configuration
  input  wire logic       sclk_in_mode,
  input  wire logic [3:0] prescale,
  input  wire logic [7:0] modulus,
  input  wire logic       long_pulse,
  // serial clock pin input
  input  wire logic       sclk_i,
  // generated clock and frame
  output logic            sclk_o,
  output logic            fr_int
);
  logic [3:0] presc_reg, presc_next;
  logic       sclk_reg, sclk_next;
  logic       sin_reg, sin_next;
  logic [8:0] bit_reg, bit_next;
  logic       fr_reg, fr_next;
  logic       edge_c;

  // prescaler: half period is prescale+1 cycles; frame counts rising sclk edges
  always_comb
  begin
    presc_next = presc_reg + 4'h1;
    sclk_next = sclk_reg;
    sin_next = sclk_i;
    if (presc_reg == prescale)
    begin
      presc_next = 4'h0;
      sclk_next = ~sclk_reg;
    end
    if (sclk_in_mode)
    begin
      presc_next = 4'h0;
      sclk_next = 1'h0;
      edge_c = sclk_i & ~sin_reg;
    end
    else
      edge_c = (presc_reg == prescale) & ~sclk_reg;
    bit_next = bit_reg;
    fr_next = fr_reg;
    if (edge_c)
    begin
      // wrap keeps frame period at modulus plus the fixed extra
      if (bit_reg >= {1'h0, modulus} + scc_pkg::FRAME_EXTRA - 9'h001)
        bit_next = 9'h000;
      else
        bit_next = bit_reg + 9'h001;
      fr_next = (bit_next < (long_pulse ? scc_pkg::LONG_FR_CLKS : scc_pkg::SHORT_FR_CLKS));
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      presc_reg <= 4'h0;
      sclk_reg <= 1'h0;
      sin_reg <= 1'h0;
      bit_reg <= 9'h000;
      fr_reg <= 1'h0;
    end
    else
    begin
      presc_reg <= presc_next;
      sclk_reg <= sclk_next;
      sin_reg <= sin_next;
      bit_reg <= bit_next;
      fr_reg <= fr_next;
    end
  end

  assign sclk_o = sclk_reg;
  assign fr_int = fr_reg;
endmodule
`default_nettype wire

// ==== core/scc_ctrl_regs.sv ====
/*
  System control word of the serial codec: lower half on I/O port 0,
  upper half on I/O port 1, interrupt flags and masks, external flag,
  companding selects, serial clock direction and frame pulse generation.
  Assumes I/O strobes are one-cycle pulses synchronous to clk and that
  the serial shift datapath and companding logic sit outside.
*/
`default_nettype none
module scc_ctrl_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // processor I/O port access
  input  wire logic        io_port,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_wdata,
  output logic [15:0]      io_rdata,
  // interrupt sources and request
  input  wire logic [2:0]  irq_src,
  output logic             irq_req,
  // serial clock pin
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  // frame sync pin
  input  wire logic        frame_sync_pulse_i,
  output logic             frame_sync_pulse_o,
  output logic             frame_sync_pulse_oe,
  output logic             xfer_start,
  // companding and misc controls
  output logic             external_flag_output,
  output logic             companding_mode_sel,
  output logic [1:0]       compand_enable,
  output logic             law_select,
  output logic [1:0]       io_ctrl
);
  logic [15:0] lower_reg, lower_next;
  logic [15:0] upper_reg, upper_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        irq_reg, irq_next;
  logic [2:0]  sync1_reg, sync2_reg, sync3_reg;
  logic        frame_reg, frame_prev_reg, xfer_reg, xfer_next;
  logic [3:0]  set_c;
  logic        fr_int, frame_rise;

  function automatic logic [3:0] flag_update(input logic [3:0] cur, input logic [3:0] clr, input logic [3:0] set);
    // set beats clear so an event in the clearing cycle is kept
    flag_update = (cur & ~clr) | set;
  endfunction

  scc_frame_gen u_frame_gen (
    .clk          (clk),
    .srst         (srst),
    .sclk_in_mode (lower_reg[scc_pkg::SHIFT_CLK_DIR_BIT]),
    .prescale     (upper_reg[scc_pkg::PRESCALE_LSB +: scc_pkg::PRESCALE_W]),
    .modulus      (upper_reg[scc_pkg::MODULUS_LSB +: scc_pkg::MODULUS_W]),
    .long_pulse   (upper_reg[scc_pkg::FR_WIDTH_BIT]),
    .sclk_i       (sclk_i),
    .sclk_o       (sclk_o),
    .fr_int       (fr_int)
  );

  assign frame_rise = frame_reg & ~frame_prev_reg;
  assign set_c = {sync2_reg & ~sync3_reg, 1'h0} | (frame_rise ? 4'h1 << scc_pkg::FRAME_FLAG_IDX : 4'h0);

  // register writes, flag updates, read data and request
  always_comb
  begin
    lower_next = lower_reg;
    upper_next = upper_reg;
    if (io_wr && io_port == scc_pkg::PORT_LOWER)
      lower_next[15:scc_pkg::MASK_LSB] = io_wdata[15:scc_pkg::MASK_LSB];
    lower_next[scc_pkg::FLAG_LSB +: scc_pkg::FLAG_W] = flag_update(lower_reg[scc_pkg::FLAG_LSB +: scc_pkg::FLAG_W],
      (io_wr && io_port == scc_pkg::PORT_LOWER) ? io_wdata[scc_pkg::FLAG_LSB +: scc_pkg::FLAG_W] : 4'h0, set_c);
    // the enable already stored gates port 1, not the one being written
    if (io_wr && io_port == scc_pkg::PORT_UPPER && lower_reg[scc_pkg::UPPER_ACCESS_BIT])
    begin
      upper_next = io_wdata;
      upper_next[scc_pkg::RESERVED_BIT] = 1'h0; // reserved bit always stored as zero
    end
    rdata_next = rdata_reg;
    if (io_rd)
      rdata_next = (io_port == scc_pkg::PORT_LOWER) ? lower_reg : upper_reg;
    irq_next = |(lower_reg[scc_pkg::FLAG_LSB +: scc_pkg::FLAG_W] & lower_reg[scc_pkg::MASK_LSB +: scc_pkg::FLAG_W]);
    xfer_next = frame_rise & lower_reg[scc_pkg::EXT_FRAMING_BIT];
  end

  // state registers; sync1 feeds only sync2
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lower_reg <= scc_pkg::LOWER_RESET;
      upper_reg <= scc_pkg::UPPER_RESET;
      rdata_reg <= 16'h0000;
      irq_reg <= 1'h0;
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      frame_reg <= 1'h0;
      frame_prev_reg <= 1'h0;
      xfer_reg <= 1'h0;
    end
    else
    begin
      lower_reg <= lower_next;
      upper_reg <= upper_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      sync1_reg <= irq_src;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // external framing takes the pin, otherwise the generated frame
      frame_reg <= lower_reg[scc_pkg::EXT_FRAMING_BIT] ? frame_sync_pulse_i : fr_int;
      frame_prev_reg <= frame_reg;
      xfer_reg <= xfer_next;
    end
  end

  // outputs straight from flip-flops, the two pin enables sclk_oe and frame_sync_pulse_oe through an inverter
  assign io_rdata = rdata_reg;
  assign irq_req = irq_reg;
  assign sclk_oe = ~lower_reg[scc_pkg::SHIFT_CLK_DIR_BIT];
  assign frame_sync_pulse_o = fr_int;
  assign frame_sync_pulse_oe = ~lower_reg[scc_pkg::EXT_FRAMING_BIT];
  assign xfer_start = xfer_reg;
  assign external_flag_output = lower_reg[scc_pkg::EXT_FLAG_BIT];
  assign companding_mode_sel = lower_reg[scc_pkg::COMPAND_MODE_BIT];
  assign compand_enable = lower_reg[scc_pkg::COMPAND_EN_LSB +: scc_pkg::COMPAND_EN_W];
  assign law_select = lower_reg[scc_pkg::LAW_SELECT_BIT];
  assign io_ctrl = upper_reg[scc_pkg::IO_CTRL_LSB +: scc_pkg::IO_CTRL_W];

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_upper_blocked: assert property (
    (io_wr && io_port && !lower_reg[8]) |=> $stable(upper_reg))
    else $error("upper half changed while access disabled");
  a_upper_written: assert property (
    (io_wr && io_port && lower_reg[8]) |=> (upper_reg == {1'b0, $past(io_wdata[14:0])}))
    else $error("enabled upper write not stored");
  a_flag_clear: assert property (
    (io_wr && !io_port && io_wdata[0] && !set_c[0]) |=> !lower_reg[0])
    else $error("flag not cleared by writing one");
  a_flag_keep: assert property (
    (io_wr && !io_port && !io_wdata[1] && lower_reg[1]) |=> lower_reg[1])
    else $error("flag lost on writing zero");
  a_set_wins: assert property (
    (frame_rise && io_wr && !io_port && io_wdata[0]) |=> lower_reg[0])
    else $error("frame event lost during clear");
  a_irq_masked: assert property (
    ((lower_reg[3:0] & lower_reg[7:4]) == 4'h0) |=> !irq_req)
    else $error("request raised with all sources masked");
  a_irq_source: assert property (
    ($rose(sync2_reg[0]) && lower_reg[5]) |=> ##1 irq_req)
    else $error("masked-in source did not raise request");
  a_xfer_start: assert property (
    $rose(frame_reg) |=> (xfer_start == $past(lower_reg[9])))
    else $error("transfer start not tied to frame and enable");
  a_clock_dir: assert property (
    lower_reg[15] |-> (!sclk_oe ##1 !sclk_o))
    else $error("serial clock driven in input mode");
  a_ext_flag: assert property (
    (io_wr && !io_port) |=> (external_flag_output == $past(io_wdata[10])))
    else $error("external flag not latched");
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
/*
  Self-checking bench for the serial codec control register bank.
  Assumes the bench alone drives every input port of scc_ctrl_regs.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, srst = 1'b1, io_port = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic [15:0] io_wdata = 16'h0000, io_rdata, rd;
  logic [2:0]  irq_src = 3'h0;
  logic        sclk_i = 1'b0, frame_sync_pulse_i = 1'b0, irq_req, sclk_o, sclk_oe;
  logic        frame_sync_pulse_o, frame_sync_pulse_oe, xfer_start, external_flag_output;
  logic        companding_mode_sel, law_select;
  logic [1:0]  compand_enable, io_ctrl;
  int          bad_count = 0, compares = 0, per, hi;
  scc_ctrl_regs i_dut (.clk(clk), .srst(srst), .io_port(io_port), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .irq_src(irq_src), .irq_req(irq_req), .sclk_i(sclk_i),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .frame_sync_pulse_i(frame_sync_pulse_i),
    .frame_sync_pulse_o(frame_sync_pulse_o), .frame_sync_pulse_oe(frame_sync_pulse_oe),
    .xfer_start(xfer_start), .external_flag_output(external_flag_output),
    .companding_mode_sel(companding_mode_sel), .compand_enable(compand_enable),
    .law_select(law_select), .io_ctrl(io_ctrl));
  // free-running 20 MHz clock
  initial forever #(scc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe; the write lands at the second edge
  task automatic io_write(input logic port, input logic [15:0] data);
    @(posedge clk);
    io_port <= port; io_wdata <= data; io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask
  // read data is registered at the taking edge, sampled half a cycle later
  task automatic io_read(input logic port);
    @(posedge clk);
    io_port <= port; io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    @(negedge clk);
    rd = io_rdata;
  endtask
  // rise-to-rise period and high time of the generated frame pulse, in clocks
  task automatic frame_meas();
    logic p;
    per = 0;
    do begin p = frame_sync_pulse_o; @(negedge clk); per++; end
    while (!(p === 1'b0 && frame_sync_pulse_o === 1'b1) && per < 900);
    per = 0; hi = 0;
    do begin if (frame_sync_pulse_o === 1'b1) hi++; p = frame_sync_pulse_o; @(negedge clk); per++; end
    while (!(p === 1'b0 && frame_sync_pulse_o === 1'b1) && per < 900);
  endtask
  task automatic t_reset_and_block();
    io_read(1'b0); check(rd, scc_pkg::LOWER_RESET);
    io_read(1'b1); check(rd, scc_pkg::UPPER_RESET);
    check({15'h0, sclk_oe}, 16'h0000);
    io_write(1'b1, 16'h7CFE);          // upper enable still clear, write must be dropped
    io_read(1'b1); check(rd, 16'h0000);
  endtask
  task automatic t_init_sequence();
    io_write(1'b0, 16'hB988);
    io_write(1'b1, 16'h7CFE);
    io_write(1'b0, 16'h3888);
    // no serial transmit or receive traffic here, so spacing holds trivially
    io_read(1'b1); check(rd, 16'h7CFE);
    check({14'h0, io_ctrl}, 16'h0003);
    io_read(1'b0); check(rd & 16'hFFF0, 16'h3880);
    check({companding_mode_sel, compand_enable, law_select}, 16'h000E);
    check({sclk_oe, external_flag_output}, 16'h0002);
  endtask
  task automatic t_interrupts();
    io_write(1'b0, 16'h812F);           // clear all flags, unmask source one only
    @(posedge clk); irq_src <= 3'h1;
    repeat (6) @(posedge clk);
    #1 check({15'h0, irq_req}, 16'h0001);
    io_read(1'b0); check(rd & 16'hFFFE, 16'h8122);
    io_write(1'b0, 16'h8122);
    repeat (3) @(posedge clk);
    #1 check({15'h0, irq_req}, 16'h0000);
    io_read(1'b0); check(rd & 16'hFFFE, 16'h8120);
    @(posedge clk); irq_src <= 3'h3;    // masked source sets its flag only
    repeat (6) @(posedge clk);
    #1 check({15'h0, irq_req}, 16'h0000);
    io_read(1'b0); check(rd & 16'hFFFE, 16'h8124);
  endtask
  task automatic t_external_frame();
    int n;
    io_write(1'b0, 16'h870F);
    @(negedge clk); check({frame_sync_pulse_oe, sclk_oe, sclk_o, external_flag_output}, 16'h0001);
    @(posedge clk); frame_sync_pulse_i <= 1'b1;
    n = 0;
    while (xfer_start !== 1'b1 && n < 6) begin @(negedge clk); n++; end
    check({15'h0, xfer_start}, 16'h0001);
    @(posedge clk); frame_sync_pulse_i <= 1'b0;
    io_read(1'b0); check(rd & 16'h0001, 16'h0001);
  endtask
  task automatic t_internal_frame();
    io_write(1'b0, 16'h010F);           // serial clock out, internal frames
    io_write(1'b1, 16'h010A);           // prescale 1, modulus 10, short pulse
    frame_meas(); frame_meas();
    check(per[15:0], 16'h0030);
    check(hi[15:0], 16'h0004);
    io_write(1'b1, 16'h110A);           // long pulse
    frame_meas(); frame_meas();
    check(hi[15:0], 16'h0020);
    io_read(1'b0); check(rd & 16'h0001, 16'h0001);
  endtask
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the scenarios need
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset_and_block();
    t_init_sequence();
    t_interrupts();
    t_external_frame();
    t_internal_frame();
    report_and_stop();
  end
endmodule
`default_nettype wire
